// ---- hw/csdu_pkg.sv ----
// Constants, register map and encodings for the clock select and divider unit
package csdu_pkg;

   // ==========================================================
   // Register indices (byte address = 4 * index)
   localparam logic [7:0] IDX_GATE_A  = 8'h63;
   localparam logic [7:0] IDX_GATE_B  = 8'h64;
   localparam logic [7:0] IDX_GATE_C  = 8'h65;
   localparam logic [7:0] IDX_SYS_SEL = 8'h66;
   localparam logic [7:0] IDX_AUD_STP = 8'h67;
   localparam logic [7:0] IDX_AUD_MOD = 8'h68;
   localparam logic [7:0] IDX_MIC_STP = 8'h6C;
   localparam logic [7:0] IDX_MIC_MOD = 8'h6D;
   localparam logic [7:0] IDX_FST_SEL = 8'h70;
   localparam logic [7:0] IDX_LF_SEL  = 8'h73;

   // ==========================================================
   // Storage slots in the register array
   localparam int unsigned NUM_SLOTS = 10;
   localparam logic [3:0] SL_GATE_A  = 4'h0;
   localparam logic [3:0] SL_GATE_B  = 4'h1;
   localparam logic [3:0] SL_GATE_C  = 4'h2;
   localparam logic [3:0] SL_SYS_SEL = 4'h3;
   localparam logic [3:0] SL_AUD_STP = 4'h4;
   localparam logic [3:0] SL_AUD_MOD = 4'h5;
   localparam logic [3:0] SL_MIC_STP = 4'h6;
   localparam logic [3:0] SL_MIC_MOD = 4'h7;
   localparam logic [3:0] SL_FST_SEL = 4'h8;
   localparam logic [3:0] SL_LF_SEL  = 4'h9;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [7:0] RST_GATE_A  = 8'h83;
   localparam logic [7:0] RST_GATE_B  = 8'h00;
   localparam logic [7:0] RST_GATE_C  = 8'h30;
   localparam logic [7:0] RST_SYS_SEL = 8'h06;
   localparam logic [7:0] RST_AUD_STP = 8'h00;
   localparam logic [7:0] RST_AUD_MOD = 8'h02;
   localparam logic [7:0] RST_MIC_STP = 8'h01;
   localparam logic [7:0] RST_MIC_MOD = 8'h02;
   localparam logic [7:0] RST_FST_SEL = 8'h00;
   localparam logic [7:0] RST_LF_SEL  = 8'h04;
   localparam logic [7:0] MSK_GATE_A  = 8'hBF;
   localparam logic [7:0] MSK_GATE_B  = 8'h1F;
   localparam logic [7:0] MSK_GATE_C  = 8'h37;
   localparam logic [7:0] MSK_FULL    = 8'hFF;

   // ==========================================================
   // Field positions
   localparam int unsigned CLK_EN_BIT  = 7;
   localparam int unsigned MIC_SRC_BIT = 1;
   localparam int unsigned LF_SEL_BIT  = 0;
   localparam int unsigned FSEL_LO_BIT = 7;
   localparam int unsigned FSEL_HI_BIT = 0;
   localparam int unsigned SRC_HI_BIT  = 6;
   localparam int unsigned SRC_LO_BIT  = 5;
   localparam int unsigned DIV_HI_BIT  = 4;

   // ==========================================================
   // System clock sources; the 32 MHz lane keeps 2 of 3 ref ticks
   typedef enum logic [1:0] {
      SRC_RC24 = 2'b00,
      SRC_FAST = 2'b01,
      SRC_FDIV = 2'b10,
      SRC_32M  = 2'b11
   } csdu_sys_src_e;
   localparam logic [1:0] R32_LAST = 2'h2;
   localparam logic [11:0] APB_ADDR_MSK = 12'hFFF;

endpackage

// ---- hw/csdu_frac_div.sv ----
// Step/modulus fractional divider producing a toggled clock level
`timescale 1ns/1ps
module csdu_frac_div
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   // Reference and settings
   input  wire logic       ref_tick,
   input  wire logic       en,
   input  wire logic [6:0] step,
   input  wire logic [7:0] modulus,
   // Divided clock
   output logic            clk_out
);

   logic [7:0] acc_reg;
   logic [8:0] sum;
   logic [8:0] rem;
   logic       wrap;
   logic       run;

   // Adding twice the step makes two wraps one period
   assign sum  = {1'b0, acc_reg} + {1'b0, step, 1'b0};
   assign wrap = sum >= {1'b0, modulus};
   assign rem  = sum - {1'b0, modulus};
   // Stop only on a low phase so the gate never clips a pulse
   assign run  = en || clk_out;

   // Accumulator and toggle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         acc_reg <= 8'h00;
         clk_out <= 1'b0;
      end
      else if (ce && ref_tick)
      begin
         if (!run)
         begin
            acc_reg <= 8'h00;
         end
         else if (wrap)
         begin
            // A modulus cut below the running total restarts the phase
            acc_reg <= (rem >= {1'b0, modulus}) ? 8'h00 : rem[7:0]; // RQ15
            clk_out <= ~clk_out;                  // RQ2
         end
         else
         begin
            acc_reg <= sum[7:0];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   wrap_toggle_a: assert property ((ce && ref_tick && run && wrap) |=> // RQ15
      (clk_out != $past(clk_out)))
      else $error("divider did not toggle on wrap");
   stop_low_a: assert property ((!en && !clk_out) |=> !clk_out) // RQ15
      else $error("disabled divider left its low phase");

endmodule

// ---- hw/csdu_top.sv ----
// Clock select, divide and gate unit with an APB register slave
//
// Operation
// RQ1: Audio clock output runs only while the audio step register top bit is one.
// RQ2: Audio clock equals 48 MHz times the 7-bit step over the 8-bit modulus.
// RQ3: Software keeps each divider modulus at least twice its step.
// RQ4: Microphone clock output runs only while the microphone step top bit is one.
// RQ5: Low-frequency select bit 1 picks the microphone divider (0) or 32 kHz (1).
// RQ6: Microphone divider uses step bits 6:0 and the next register as modulus.
// RQ7: Low-frequency select bit 0 picks the RC (0) or crystal (1) 32 kHz source.
// RQ8: System select bits 6:5 pick RC 24, fast, divided fast or the 32 MHz lane.
// RQ9: Divided fast mode gives fast source frequency over select bits 4:0.
// RQ10: Software never loads the system divider field with zero or one.
// RQ11: Fast source is 48 MHz, RC 24 or crystal 24 by the two select bits.
// RQ12: Gate register A enables SPI, I2C, UART, USB, PWM, decoder and debug port.
// RQ13: Gate register B enables radio core, timer, DMA, algorithm unit and AES.
// RQ14: Gate register C enables audio interface, audio, data FIFO, mic core, filter.
// RQ15: Dividers are step accumulators toggling on wrap and switch glitch-free.
`timescale 1ns/1ps
module csdu_top
(
   // Clock, reset, freeze
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Source clocks as one-cycle ticks or levels
   input  wire logic        ref48_tick,
   input  wire logic        internal_24mhz_rc,
   input  wire logic        crystal_24mhz_source,
   input  wire logic        internal_32khz_rc,
   input  wire logic        crystal_32khz_source,
   // Produced clocks
   output logic             sys_clk_tick,
   output logic             fast_source_clock,
   output logic             audio_clk,
   output logic             digital_microphone_clk,
   // Module clock enables
   output logic [7:0]       gate_a_en,
   output logic [7:0]       gate_b_en,
   output logic [7:0]       gate_c_en
);

   // ==========================================================
   // Address decode helpers
   function automatic logic [4:0] slot_of(input logic [11:0] addr);
      logic [9:0] idx;
      idx = addr[11:2];
      slot_of = 5'h10;
      if (addr[1:0] == 2'b00)
      begin
         unique case (idx)
            {2'b00, csdu_pkg::IDX_GATE_A}:  slot_of = {1'b0, csdu_pkg::SL_GATE_A};
            {2'b00, csdu_pkg::IDX_GATE_B}:  slot_of = {1'b0, csdu_pkg::SL_GATE_B};
            {2'b00, csdu_pkg::IDX_GATE_C}:  slot_of = {1'b0, csdu_pkg::SL_GATE_C};
            {2'b00, csdu_pkg::IDX_SYS_SEL}: slot_of = {1'b0, csdu_pkg::SL_SYS_SEL};
            {2'b00, csdu_pkg::IDX_AUD_STP}: slot_of = {1'b0, csdu_pkg::SL_AUD_STP};
            {2'b00, csdu_pkg::IDX_AUD_MOD}: slot_of = {1'b0, csdu_pkg::SL_AUD_MOD};
            {2'b00, csdu_pkg::IDX_MIC_STP}: slot_of = {1'b0, csdu_pkg::SL_MIC_STP};
            {2'b00, csdu_pkg::IDX_MIC_MOD}: slot_of = {1'b0, csdu_pkg::SL_MIC_MOD};
            {2'b00, csdu_pkg::IDX_FST_SEL}: slot_of = {1'b0, csdu_pkg::SL_FST_SEL};
            {2'b00, csdu_pkg::IDX_LF_SEL}:  slot_of = {1'b0, csdu_pkg::SL_LF_SEL};
            default:                        slot_of = 5'h10;
         endcase
      end
   endfunction

   // Reserved gate bits never store and read back as zero
   function automatic logic [7:0] mask_of(input logic [3:0] sl);
      unique case (sl)
         csdu_pkg::SL_GATE_A: mask_of = csdu_pkg::MSK_GATE_A;
         csdu_pkg::SL_GATE_B: mask_of = csdu_pkg::MSK_GATE_B;
         csdu_pkg::SL_GATE_C: mask_of = csdu_pkg::MSK_GATE_C;
         default:             mask_of = csdu_pkg::MSK_FULL;
      endcase
   endfunction

   function automatic logic [7:0] reset_of(input int unsigned sl);
      unique case (sl)
         0:       reset_of = csdu_pkg::RST_GATE_A;
         1:       reset_of = csdu_pkg::RST_GATE_B;
         2:       reset_of = csdu_pkg::RST_GATE_C;
         3:       reset_of = csdu_pkg::RST_SYS_SEL;
         4:       reset_of = csdu_pkg::RST_AUD_STP;
         5:       reset_of = csdu_pkg::RST_AUD_MOD;
         6:       reset_of = csdu_pkg::RST_MIC_STP;
         7:       reset_of = csdu_pkg::RST_MIC_MOD;
         8:       reset_of = csdu_pkg::RST_FST_SEL;
         default: reset_of = csdu_pkg::RST_LF_SEL;
      endcase
   endfunction

   // ==========================================================
   // APB slave
   logic [7:0]  regs_reg [csdu_pkg::NUM_SLOTS];
   logic [4:0]  hit_slot;
   logic        hit;
   logic        wr_go;

   assign hit_slot = slot_of(paddr & csdu_pkg::APB_ADDR_MSK);
   assign hit      = !hit_slot[4];
   // A frozen block cannot take the access, so it stretches it
   assign pready   = ce;
   assign pslverr  = psel && penable && !hit;
   assign wr_go    = psel && penable && pwrite && ce && hit && pstrb[0];

   // Register array; only byte lane 0 carries data
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < csdu_pkg::NUM_SLOTS; i++)
         begin
            regs_reg[i] <= reset_of(i);
         end
      end
      else if (wr_go)
      begin
         regs_reg[hit_slot[3:0]] <= pwdata[7:0] & mask_of(hit_slot[3:0]);
      end
   end

   // Read data captured in the setup cycle, answered in access
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (ce && psel && !penable)
      begin
         prdata <= hit ? {24'h00_0000, regs_reg[hit_slot[3:0]]} : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Field views
   logic [7:0] sys_sel;
   logic [1:0] fsel;
   logic [4:0] sys_div;
   logic [7:0] lf_sel;
   logic [7:0] mic_stp;
   logic [7:0] aud_stp;
   csdu_pkg::csdu_sys_src_e sys_src;

   assign sys_sel = regs_reg[csdu_pkg::SL_SYS_SEL];
   assign lf_sel  = regs_reg[csdu_pkg::SL_LF_SEL];
   assign mic_stp = regs_reg[csdu_pkg::SL_MIC_STP];
   assign aud_stp = regs_reg[csdu_pkg::SL_AUD_STP];
   assign fsel    = {regs_reg[csdu_pkg::SL_FST_SEL][csdu_pkg::FSEL_HI_BIT],
                     sys_sel[csdu_pkg::FSEL_LO_BIT]};
   assign sys_div = sys_sel[csdu_pkg::DIV_HI_BIT:0];
   assign sys_src = csdu_pkg::csdu_sys_src_e'(
                    sys_sel[csdu_pkg::SRC_HI_BIT:csdu_pkg::SRC_LO_BIT]);

   // Module clock enables straight from the gate registers
   assign gate_a_en = regs_reg[csdu_pkg::SL_GATE_A]; // RQ12
   assign gate_b_en = regs_reg[csdu_pkg::SL_GATE_B]; // RQ13
   assign gate_c_en = regs_reg[csdu_pkg::SL_GATE_C]; // RQ14

   // ==========================================================
   // Fast source and system clock lanes
   logic       fast_tick;
   logic [4:0] fdiv_cnt_reg;
   logic       fdiv_pulse;
   logic [1:0] r32_cnt_reg;
   logic       r32_pulse;
   logic       sys_next;

   // Fast source pick; bit 1 set means the 24 MHz crystal
   always_comb
   begin
      unique casez (fsel)
         2'b00:   fast_tick = ref48_tick;           // RQ11
         2'b01:   fast_tick = internal_24mhz_rc;    // RQ11
         default: fast_tick = crystal_24mhz_source; // RQ11
      endcase
   end

   // Divide fast ticks by the divider field; zero and one are illegal
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fdiv_cnt_reg <= 5'h00;
      end
      else if (ce && fast_tick)
      begin
         if (fdiv_cnt_reg >= 5'(sys_div - 5'h01)) // RQ9
         begin
            fdiv_cnt_reg <= 5'h00;
         end
         else
         begin
            fdiv_cnt_reg <= 5'(fdiv_cnt_reg + 5'h01);
         end
      end
   end
   assign fdiv_pulse = fast_tick && (fdiv_cnt_reg >= 5'(sys_div - 5'h01)); // RQ9

   // 48 MHz times 2/3: keep two ref ticks, drop the third
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         r32_cnt_reg <= 2'h0;
      end
      else if (ce && ref48_tick)
      begin
         r32_cnt_reg <= (r32_cnt_reg == csdu_pkg::R32_LAST) ? 2'h0 : 2'(r32_cnt_reg + 2'h1);
      end
   end
   assign r32_pulse = ref48_tick && (r32_cnt_reg != csdu_pkg::R32_LAST);

   // Tick lanes cannot glitch, so a select change is clean at once
   always_comb
   begin
      unique case (sys_src)
         csdu_pkg::SRC_RC24: sys_next = internal_24mhz_rc; // RQ8
         csdu_pkg::SRC_FAST: sys_next = fast_tick;         // RQ8
         csdu_pkg::SRC_FDIV: sys_next = fdiv_pulse;        // RQ8
         csdu_pkg::SRC_32M:  sys_next = r32_pulse;         // RQ8
      endcase
   end

   // Registered clock tick outputs
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sys_clk_tick      <= 1'b0;
         fast_source_clock <= 1'b0;
      end
      else if (ce)
      begin
         sys_clk_tick      <= sys_next;
         fast_source_clock <= fast_tick;
      end
   end

   // ==========================================================
   // Audio and microphone dividers
   logic aud_div;
   logic mic_div;
   logic lf_clk;
   logic mic_pick;
   logic mic_src_reg;
   logic mic_on_reg;

   csdu_frac_div u_aud_div
   (
      .clk      (clk),
      .rstn     (rstn),
      .ce       (ce),
      .ref_tick (ref48_tick),
      .en       (aud_stp[csdu_pkg::CLK_EN_BIT]), // RQ1
      .step     (aud_stp[6:0]),                  // RQ2
      .modulus  (regs_reg[csdu_pkg::SL_AUD_MOD]),
      .clk_out  (aud_div)
   );

   csdu_frac_div u_mic_div
   (
      .clk      (clk),
      .rstn     (rstn),
      .ce       (ce),
      .ref_tick (ref48_tick),
      .en       (1'b1),
      .step     (mic_stp[6:0]),                  // RQ6
      .modulus  (regs_reg[csdu_pkg::SL_MIC_MOD]), // RQ6
      .clk_out  (mic_div)
   );

   assign audio_clk = aud_div;
   // 32 kHz source: RC when bit is zero, crystal when one
   assign lf_clk = lf_sel[csdu_pkg::LF_SEL_BIT] ? crystal_32khz_source
                                                : internal_32khz_rc; // RQ7
   assign mic_pick = mic_src_reg ? lf_clk : mic_div;

   // Gate moves only while pin and picked source sit low; source also needs both sides low
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mic_src_reg <= 1'b0;
         mic_on_reg  <= 1'b0;
      end
      else if (ce && !digital_microphone_clk && !mic_pick)
      begin
         if (!mic_div && !lf_clk)
         begin
            mic_src_reg <= lf_sel[csdu_pkg::MIC_SRC_BIT]; // RQ5
         end
         mic_on_reg <= mic_stp[csdu_pkg::CLK_EN_BIT]; // RQ4
      end
   end

   // Registered microphone clock pin
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         digital_microphone_clk <= 1'b0;
      end
      else if (ce)
      begin
         digital_microphone_clk <= mic_on_reg && mic_pick; // RQ4
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence apb_wr_s(logic [3:0] sl);
      wr_go && hit_slot[3:0] == sl;
   endsequence

   gate_a_write_a: assert property (apb_wr_s(csdu_pkg::SL_GATE_A) |=> // RQ12
      gate_a_en == ($past(pwdata[7:0]) & 8'hBF))
      else $error("gate A write not reflected");
   gate_b_write_a: assert property (apb_wr_s(csdu_pkg::SL_GATE_B) |=> // RQ13
      gate_b_en == ($past(pwdata[7:0]) & 8'h1F))
      else $error("gate B write not reflected");
   gate_c_resv_a: assert property (gate_c_en[7:6] == 2'b00 && !gate_c_en[3]) // RQ14
      else $error("gate C reserved bit set");
   audio_off_a: assert property ((!aud_stp[7] && !audio_clk) |=> !audio_clk) // RQ1
      else $error("audio clock ran while disabled");
   mic_off_a: assert property ((!mic_on_reg && ce) |=> !digital_microphone_clk) // RQ4
      else $error("mic clock ran while disabled");
   mic_lf_a: assert property ((ce && mic_on_reg && mic_src_reg && // RQ5
      !lf_sel[0]) |=> digital_microphone_clk == $past(internal_32khz_rc))
      else $error("mic clock not following RC 32 kHz");
   mic_xtal_a: assert property ((ce && mic_on_reg && mic_src_reg && // RQ7
      lf_sel[0]) |=> digital_microphone_clk == $past(crystal_32khz_source))
      else $error("mic clock not following crystal 32 kHz");
   sys_rc_a: assert property ((ce && sys_src == csdu_pkg::SRC_RC24) |=> // RQ8
      sys_clk_tick == $past(internal_24mhz_rc))
      else $error("system clock not on RC 24");
   fast_xtal_a: assert property ((ce && fsel[1]) |=> // RQ11
      fast_source_clock == $past(crystal_24mhz_source))
      else $error("fast source not on crystal");
   fdiv_space_a: assert property ((ce && sys_src == csdu_pkg::SRC_FDIV && // RQ9
      sys_div > 5'h01 && fdiv_pulse) |=> !fdiv_pulse)
      else $error("divided fast pulses back to back");
   r32_drop_a: assert property ((ce && sys_src == csdu_pkg::SRC_32M && ref48_tick && // RQ8
      r32_cnt_reg == csdu_pkg::R32_LAST) |=> !sys_clk_tick)
      else $error("32 MHz lane kept third tick");

endmodule

// ---- dv/csdu_tb.sv ----
// Self-checking register and clock-rate testbench for the clock select and divider unit
`timescale 1ns/1ps
module testbench;

   // ==========================================================
   // Stimulus and observed signals
   logic        clk                  = 1'b0;
   logic        rstn                 = 1'b0;
   logic        ce                   = 1'b1;
   logic        psel                 = 1'b0;
   logic        penable              = 1'b0;
   logic        pwrite               = 1'b0;
   logic [11:0] paddr                = 12'h000;
   logic [31:0] pwdata               = 32'h0000_0000;
   logic [3:0]  pstrb                = 4'hF;
   logic        ref48_tick           = 1'b0;
   logic        internal_24mhz_rc    = 1'b0;
   logic        crystal_24mhz_source = 1'b0;
   logic        internal_32khz_rc    = 1'b0;
   logic        crystal_32khz_source = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, sys_clk_tick, fast_source_clock;
   logic        audio_clk, digital_microphone_clk;
   logic [7:0]  gate_a_en, gate_b_en, gate_c_en;
   logic [15:0] cyc                  = 16'h0000;
   logic        win                  = 1'b0;
   logic        aud_q                = 1'b0;
   logic        mic_q                = 1'b0;
   int          n_sys, n_fast, n_aud, n_mic;
   int          error_cnt            = 0;
   int          num_checks           = 0;
   logic [31:0] r;
   logic        e;

   // ==========================================================
   // Register table as software sees it
   logic [7:0]  r_idx[10] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h6C, 8'h6D,
                              8'h70, 8'h73};
   logic [7:0]  r_rst[10] = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00, 8'h02, 8'h01, 8'h02,
                              8'h00, 8'h04};
   logic [7:0]  r_msk[10] = '{8'hBF, 8'h1F, 8'h37, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                              8'hFF, 8'hFF};

   // Clock of 50 MHz
   always #10 clk = ~clk;

   csdu_top csdu_top_i
   (
      .clk(clk), .rstn(rstn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ref48_tick(ref48_tick),
      .internal_24mhz_rc(internal_24mhz_rc), .crystal_24mhz_source(crystal_24mhz_source),
      .internal_32khz_rc(internal_32khz_rc), .crystal_32khz_source(crystal_32khz_source),
      .sys_clk_tick(sys_clk_tick), .fast_source_clock(fast_source_clock),
      .audio_clk(audio_clk), .digital_microphone_clk(digital_microphone_clk),
      .gate_a_en(gate_a_en), .gate_b_en(gate_b_en), .gate_c_en(gate_c_en)
   );

   // ==========================================================
   // Source ticks with distinct rates so each mux lane has its own count
   always @(posedge clk)
   begin
      cyc <= cyc + 16'h0001;
      ref48_tick <= 1'b1;
      internal_24mhz_rc <= (cyc[0] == 1'b0);
      crystal_24mhz_source <= (cyc[1:0] == 2'b00);
      internal_32khz_rc <= cyc[2];
      crystal_32khz_source <= (((cyc / 6) % 2) == 1);
   end

   // Count pulses and level toggles inside the measuring window
   always @(posedge clk)
   begin
      if (win)
      begin
         n_sys += (sys_clk_tick === 1'b1);
         n_fast += (fast_source_clock === 1'b1);
         n_aud += (audio_clk !== aud_q);
         n_mic += (digital_microphone_clk !== mic_q);
      end
      aud_q = audio_clk;
      mic_q = digital_microphone_clk;
   end

   // ==========================================================
   // Compare tasks and the closing task
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", nm, ex, got);
      end
   endtask

   // Counts over a window may drift by a phase step at either end
   task automatic chk_near(input string nm, input int ex, input int got);
      num_checks++;
      if (got < ex - 2 || got > ex + 2)
      begin
         error_cnt++;
         $display("mismatch %s expected %0d seen %0d", nm, ex, got);
      end
   endtask

   task automatic stop_test;
      if (error_cnt == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================================
   // APB master: setup, access held until pready, then release
   task automatic apb(input logic wr_en, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= {24'h000000, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, {2'b00, idx, 2'b00}, d, 4'hF, r, e);
   endtask

   task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] ex);
      apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, 4'hF, r, e);
      chk(nm, {24'h000000, ex}, r);
   endtask

   // Let selections settle, then count 120 edges
   task automatic measure;
      repeat (30) @(posedge clk);
      n_sys = 0;
      n_fast = 0;
      n_aud = 0;
      n_mic = 0;
      win <= 1'b1;
      repeat (120) @(posedge clk);
      win <= 1'b0;
   endtask

   // ==========================================================
   // Watchdog: the whole sequence needs well under 10000 cycles
   initial
   begin
      #200000;
      error_cnt++;
      stop_test;
   end

   // ==========================================================
   // Test sequence
   // Tables: {fast sel, sys sel, sys count, fast count}, {step, mod, toggles}, {lf, step, mod, toggles}
   int sys_t[8][4] = '{'{0, 'h02, 60, 120}, '{0, 'h22, 120, 120}, '{0, 'hA2, 60, 60},
                       '{0, 'h43, 40, 120}, '{0, 'h62, 80, 120}, '{1, 'h22, 30, 30},
                       '{1, 'hA2, 30, 30}, '{1, 'h42, 15, 30}};
   int aud_t[5][3] = '{'{'h81, 'h02, 120}, '{'h81, 'h04, 60}, '{'h83, 'h0A, 72},
                       '{'hFF, 'hFE, 120}, '{'h01, 'h02, 0}};
   int mic_t[5][4] = '{'{'h00, 'h81, 'h04, 60}, '{'h00, 'h83, 'h0A, 72},
                       '{'h02, 'h81, 'h04, 30}, '{'h03, 'h81, 'h04, 20},
                       '{'h02, 'h01, 'h04, 0}};
   initial
   begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk("gate_a_en", 32'h83, {24'h0, gate_a_en});
      chk("gate_c_en", 32'h30, {24'h0, gate_c_en});
      for (int i = 0; i < 10; i++)
         rdc("reset value", r_idx[i], r_rst[i]);
      // Reserved gate bits must not stick; moduli go before steps
      for (int i = 9; i >= 0; i--)
      begin
         wr(r_idx[i], 8'hFF);
         rdc("write mask", r_idx[i], r_msk[i]);
      end
      chk("gate_a_en", 32'hBF, {24'h0, gate_a_en});
      chk("gate_b_en", 32'h1F, {24'h0, gate_b_en});
      chk("gate_c_en", 32'h37, {24'h0, gate_c_en});
      // Refused accesses: unknown index, misaligned, no byte strobe
      apb(1'b0, 12'h1A4, 8'h00, 4'hF, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
      apb(1'b1, 12'h18D, 8'h00, 4'hF, r, e);
      chk("misaligned err", 32'h1, {31'h0, e});
      apb(1'b1, 12'h190, 8'h00, 4'h0, r, e);
      rdc("strobe off", 8'h64, 8'h1F);
      // Frozen unit holds the bus waiting
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      #1;
      chk("pready frozen", 32'h0, {31'h0, pready});
      @(posedge clk);
      ce <= 1'b1;
      // System and fast source selection, divider boundary included
      for (int t = 0; t < 8; t++)
      begin
         wr(8'h70, sys_t[t][0]);
         wr(8'h66, sys_t[t][1]);
         measure;
         chk_near("sys_clk_tick", sys_t[t][2], n_sys);
         chk_near("fast_source_clock", sys_t[t][3], n_fast);
      end
      // Audio divider rates and gate
      for (int t = 0; t < 5; t++)
      begin
         // Drop to step one first so no step/modulus pair goes illegal
         wr(8'h67, 8'h01);
         wr(8'h68, aud_t[t][1]);
         wr(8'h67, aud_t[t][0]);
         measure;
         chk_near("audio_clk", aud_t[t][2], n_aud);
      end
      // Microphone divider, 32 kHz sources and gate
      for (int t = 0; t < 5; t++)
      begin
         wr(8'h73, mic_t[t][0]);
         wr(8'h6C, 8'h01);
         wr(8'h6D, mic_t[t][2]);
         wr(8'h6C, mic_t[t][1]);
         measure;
         chk_near("digital_microphone_clk", mic_t[t][3], n_mic);
      end
      stop_test;
   end

endmodule
